// file: smz_pkg.sv
// Shared constants and types for the calibration-pattern command link.
package smz_pkg;

  // ==========================================================
  // Link commands
  typedef enum logic [2:0] {
    SMZ_NOP  = 3'b000,
    SMZ_MRS  = 3'b001,
    SMZ_RD   = 3'b010,
    SMZ_RDA  = 3'b011,
    SMZ_WR   = 3'b100,
    SMZ_PREA = 3'b101,
    SMZ_LONG_IMPEDANCE_CALIBRATION = 3'b110,
    SMZ_SHORT_IMPEDANCE_CALIBRATION = 3'b111
  } smz_cmd_e;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 50000;
  localparam int PRECHARGE_PERIOD_PS = 13750;
  localparam int PRECHARGE_PERIOD_CYC =
    (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MODE_SET_COMMAND_GAP_CYC = 4;
  localparam int MODE_SET_UPDATE_DELAY_CYC = 12;
  localparam int PATTERN_READ_RECOVERY_CYC = 1;
  localparam int INITIAL_CALIBRATION_CYC = 512;
  localparam int OPERATING_CALIBRATION_CYC = 256;
  localparam int SHORT_CALIBRATION_CYC = 64;
  localparam int READ_TIMEOUT_CYC = 40;
  localparam int TMR_W = 10;

  // ==========================================================
  // Mode register fields
  localparam logic [13:0] MODE_REG_RESET = 14'h0000;
  localparam int MR0_BURST_LSB = 0;
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;
  localparam int MR0_COLUMN_LATENCY_LSB = 4;
  localparam logic [3:0] COLUMN_LATENCY_BASE = 4'h5;
  localparam int MR1_ADDITIVE_LATENCY_LSB = 3;
  localparam int MR3_ENABLE_BIT = 2;
  localparam int MR3_FUNC_LSB = 0;
  localparam logic [1:0] FUNC_PATTERN = 2'h0;
  localparam logic [2:0] MR3_SELECT = 3'h3;
  localparam int ADDR_CHOP_BIT = 12;
  localparam int ADDR_NIBBLE_BIT = 2;
  localparam logic [7:0] CAL_PATTERN = 8'haa;

  // ==========================================================
  // Controller register map and operations
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_BANK = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CAPTURE = 4'h5;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READOUT_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_ODT_BIT = 3;
  localparam logic [2:0] OP_MRS = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_ZQ_LONG = 3'h3;
  localparam logic [2:0] OP_ZQ_SHORT = 3'h4;

endpackage

// file: smz_link_if.sv
// Command, address and data link between controller and memory device.
`timescale 1ns/1ps
`default_nettype none
interface smz_link_if;
  import smz_pkg::*;
  smz_cmd_e cmd;
  logic cke;
  logic on_die_termination;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [15:0] ctl_dq;
  logic ctl_dq_oe;
  logic [15:0] dev_dq;
  logic dev_dq_oe;
  logic [15:0] dq;

  // Resolved data bus level; an undriven bus reads low.
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : 16'h0000);

  modport dev (
    input cmd, cke, on_die_termination, ba, addr, dq,
    output dev_dq, dev_dq_oe
  );
  modport ctl (
    output cmd, cke, on_die_termination, ba, addr, ctl_dq, ctl_dq_oe,
    input dq, dev_dq_oe
  );
endinterface
`default_nettype wire

// file: smz_timer.sv
// Loadable down-counter that reports when it has run out.
`timescale 1ns/1ps
`default_nettype none
module smz_timer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [smz_pkg::TMR_W-1:0] val_i,
  output logic zero_o
);
  import smz_pkg::*;
  logic [TMR_W-1:0] cnt_ff;

  // Count down from the loaded value and stop at zero.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= val_i;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign zero_o = (cnt_ff == '0);
endmodule
`default_nettype wire

// file: smz_dev.sv
// Memory device end: mode registers, pattern readout and calibration.
`timescale 1ns/1ps
`default_nettype none
module smz_dev (
  input wire logic clk_i,
  input wire logic arst_n_i,
  smz_link_if.dev link,
  input wire logic all_lines_i,
  output logic readout_on_o,
  output logic cal_busy_o
);
  import smz_pkg::*;
  logic [13:0] mode_ff [4];
  logic pend_ff;
  logic [1:0] pend_sel_ff;
  logic [13:0] pend_val_ff;
  logic upd_zero, cal_zero, cal_init_done_ff;
  logic is_mrs, is_rd, is_wr, is_zq, rd_go, start, chop, readout_en;
  logic [1:0] func, burst;
  logic [3:0] cl;
  logic [4:0] rl, lat_ff;
  logic rd_pend_ff, rd_chop_ff, rd_nib_ff, rd_mpr_ff, oe_ff, bitv;
  logic [2:0] beat_ff, left_ff, cur_beat;
  logic [15:0] dq_ff, array_ff, word;

  // ==========================================================
  // Command decode
  assign is_mrs = link.cke && (link.cmd == SMZ_MRS);
  assign is_rd = link.cke && (link.cmd == SMZ_RD || link.cmd == SMZ_RDA);
  assign is_wr = link.cke && (link.cmd == SMZ_WR);
  assign is_zq = link.cke && (link.cmd == SMZ_LONG_IMPEDANCE_CALIBRATION || link.cmd == SMZ_SHORT_IMPEDANCE_CALIBRATION);

  // ==========================================================
  // Mode set: value is staged and applied after the update delay.
  // RULE16 update delay
  smz_timer u_upd (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(is_mrs && !link.ba[2]),
    .val_i(TMR_W'(MODE_SET_UPDATE_DELAY_CYC)),
    .zero_o(upd_zero)
  );

  // RULE14 bank selects register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_ff <= 1'b0;
      pend_sel_ff <= 2'h0;
      pend_val_ff <= MODE_REG_RESET;
    end else if (is_mrs && !link.ba[2]) begin
      pend_ff <= 1'b1;
      pend_sel_ff <= link.ba[1:0];
      pend_val_ff <= link.addr;
    end else if (pend_ff && upd_zero) begin
      pend_ff <= 1'b0;
    end
  end

  // Commit the staged value into the selected mode register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        mode_ff[i] <= MODE_REG_RESET;
      end
    end else if (pend_ff && upd_zero) begin
      mode_ff[pend_sel_ff] <= pend_val_ff;
    end
  end

  // ==========================================================
  // Read setup
  assign readout_en = mode_ff[3][MR3_ENABLE_BIT];
  assign func = mode_ff[3][MR3_FUNC_LSB +: 2];
  assign burst = mode_ff[0][MR0_BURST_LSB +: 2];
  // RULE8 on-the-fly chop
  assign chop = (burst == BURST_FIXED_CHOP) ||
    (burst == BURST_ON_THE_FLY && !link.addr[ADDR_CHOP_BIT]);
  assign cl = {1'b0, mode_ff[0][MR0_COLUMN_LATENCY_LSB +: 3]} +
    COLUMN_LATENCY_BASE;
  // RULE12 latency sum
  assign rl = {1'b0, cl} +
    {3'h0, mode_ff[1][MR1_ADDITIVE_LATENCY_LSB +: 2]};
  // RULE9 reserved functions silent
  assign rd_go = is_rd && !rd_pend_ff && !oe_ff &&
    !(readout_en && func != FUNC_PATTERN);

  // Latch the read and count down its latency.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_pend_ff <= 1'b0;
      lat_ff <= 5'h00;
      rd_chop_ff <= 1'b0;
      rd_nib_ff <= 1'b0;
      rd_mpr_ff <= 1'b0;
    end else if (rd_go) begin
      rd_pend_ff <= 1'b1;
      lat_ff <= rl - 5'h02; // Start pulse and output flop take two.
      rd_chop_ff <= chop;
      // RULE7 other address ignored
      rd_nib_ff <= link.addr[ADDR_NIBBLE_BIT];
      rd_mpr_ff <= readout_en;
    end else if (rd_pend_ff) begin
      if (lat_ff == 5'h00) begin
        rd_pend_ff <= 1'b0;
      end else begin
        lat_ff <= lat_ff - 5'h01;
      end
    end
  end

  // ==========================================================
  // Burst output
  assign start = rd_pend_ff && (lat_ff == 5'h00);
  // RULE5 chop nibble select
  // RULE4 eight-beat from zero
  assign cur_beat = start ? {rd_nib_ff && rd_chop_ff, 2'h0} : beat_ff;
  // RULE6 beat indexes pattern bit
  assign bitv = CAL_PATTERN[cur_beat];

  // RULE1 prime or all lines
  always_comb begin
    word = array_ff;
    if (rd_mpr_ff) begin
      word = all_lines_i ? {16{bitv}} : {7'h00, bitv, 7'h00, bitv};
    end
  end

  // RULE2 normal latency bursts
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_ff <= 1'b0;
      dq_ff <= 16'h0000;
      beat_ff <= 3'h0;
      left_ff <= 3'h0;
    end else if (start) begin
      oe_ff <= 1'b1;
      dq_ff <= word;
      beat_ff <= cur_beat + 3'h1;
      left_ff <= rd_chop_ff ? 3'h3 : 3'h7;
    end else if (left_ff != 3'h0) begin
      dq_ff <= word;
      beat_ff <= beat_ff + 3'h1;
      left_ff <= left_ff - 3'h1;
    end else begin
      oe_ff <= 1'b0;
    end
  end

  // RULE13 array again after exit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      array_ff <= 16'h0000;
    end else if (is_wr && !readout_en) begin
      array_ff <= link.dq;
    end
  end

  // ==========================================================
  // Impedance calibration
  // RULE17 long and short
  smz_timer u_cal (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(is_zq && cal_zero),
    .val_i(link.cmd == SMZ_SHORT_IMPEDANCE_CALIBRATION ? TMR_W'(SHORT_CALIBRATION_CYC) :
      (cal_init_done_ff ? TMR_W'(OPERATING_CALIBRATION_CYC) :
      TMR_W'(INITIAL_CALIBRATION_CYC))),
    .zero_o(cal_zero)
  );

  // The first long calibration is the power-up one.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_init_done_ff <= 1'b0;
    end else if (is_zq && cal_zero && link.cmd == SMZ_LONG_IMPEDANCE_CALIBRATION) begin
      cal_init_done_ff <= 1'b1;
    end
  end

  assign link.dev_dq = dq_ff;
  assign link.dev_dq_oe = oe_ff;
  assign readout_on_o = readout_en;
  assign cal_busy_o = !cal_zero;
endmodule
`default_nettype wire

// file: smz_ctl.sv
// Memory controller end: sequences mode set, pattern reads and calibration.
// Notes on behaviour
// RULE1 - Pattern on prime line or all lines.
// RULE2 - Readout in eight-beat or chop, normal latency.
// RULE3 - Controller drives column bits one, zero low.
// RULE4 - Eight-beat read: bit two low, beats 0-7.
// RULE5 - Chop picks beats 0-3 or 4-7.
// RULE6 - First beat least significant, last most.
// RULE7 - Readout ignores other address and bank bits.
// RULE8 - Bit twelve chops when enabled in register zero.
// RULE9 - Function zero gives 01010101; others reserved.
// RULE10 - Precharge, wait, set register three to enter.
// RULE11 - No writes while readout is enabled.
// RULE12 - Pattern starts after additive plus column latency.
// RULE13 - Wait recovery, clear enable, array resumes.
// RULE14 - Bank bits pick which mode register loads.
// RULE15 - Mode set only with banks idle, precharged.
// RULE16 - Wait command gap and update delay after set.
// RULE17 - Device accepts long and short calibration.
// RULE18 - Calibrate only after precharge period elapses.
// RULE19 - Channel quiet during whole calibration time.
// RULE20 - Calibration may overlap loop reset; explicit after.
// RULE21 - Shared resistor ranks never overlap calibration.
// RULE22 - Clock enable high, termination off when calibrating.
// RULE23 - Readout allows only reads until disabled.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module smz_ctl (
  input wire logic clk_i,
  input wire logic arst_n_i,
  smz_link_if.ctl link,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o
);
  import smz_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_TRP = 3'b001,
    S_WAIT = 3'b010,
    S_CAL = 3'b011,
    S_RDW = 3'b100,
    S_REC = 3'b101
  } smz_state_e;

  smz_state_e state_ff, iss_nxt;
  smz_cmd_e cmd_ff, iss_cmd;
  logic [13:0] addr_ff, a_ff, iss_addr;
  logic [2:0] bank_ff, ba_ff, op_ff, op_sel;
  logic [15:0] wdata_ff, wdq_ff, rdata_ff;
  logic [7:0] cap_ff;
  logic [2:0] idx_ff;
  logic readout_ff, err_ff, odt_en_ff, odt_ff, cke_ff, zq_done_ff;
  logic wdq_oe_ff, seen_ff;
  logic cmd_wr, refuse, go, need_pre, pre, fire, rec, rd_end;
  logic tmr_load, tmr_zero;
  logic [TMR_W-1:0] iss_tmr, tmr_val;

  // ==========================================================
  // Order acceptance
  assign cmd_wr = reg_wr_i && (reg_addr_i == REG_CMD);
  // RULE11 no writes in readout
  // RULE23 only reads in readout
  assign refuse = (state_ff != S_IDLE) || (reg_wdata_i[2:0] > OP_ZQ_SHORT) ||
    (readout_ff && reg_wdata_i[2:0] != OP_READ &&
    reg_wdata_i[2:0] != OP_MRS);
  assign go = cmd_wr && !refuse;
  // RULE10 precharge before entry
  // RULE15 banks idle before set
  // RULE18 precharge before calibration
  assign need_pre = !readout_ff && (reg_wdata_i[2:0] != OP_READ) &&
    (reg_wdata_i[2:0] != OP_WRITE);
  assign op_sel = (state_ff == S_IDLE) ? reg_wdata_i[2:0] : op_ff;
  assign pre = (state_ff == S_IDLE) && go && need_pre;
  assign fire = ((state_ff == S_IDLE) && go && !need_pre) ||
    ((state_ff == S_TRP) && tmr_zero);
  assign rd_end = (seen_ff && !link.dev_dq_oe) || tmr_zero;
  assign rec = (state_ff == S_RDW) && rd_end;

  // What to drive when the selected operation is issued.
  always_comb begin
    iss_cmd = SMZ_NOP;
    iss_addr = addr_ff;
    iss_nxt = S_IDLE;
    iss_tmr = '0;
    case (op_sel)
      OP_MRS: begin
        iss_cmd = SMZ_MRS;
        iss_nxt = S_WAIT;
        // RULE16 gap and update delay
        iss_tmr = TMR_W'(MODE_SET_UPDATE_DELAY_CYC >
          MODE_SET_COMMAND_GAP_CYC ? MODE_SET_UPDATE_DELAY_CYC :
          MODE_SET_COMMAND_GAP_CYC);
      end
      OP_READ: begin
        iss_cmd = SMZ_RD;
        // RULE3 column bits low
        iss_addr[1:0] = 2'h0;
        // RULE4 bit two low
        if (addr_ff[ADDR_CHOP_BIT]) begin
          iss_addr[ADDR_NIBBLE_BIT] = 1'b0;
        end
        iss_nxt = S_RDW;
        iss_tmr = TMR_W'(READ_TIMEOUT_CYC);
      end
      OP_WRITE: begin
        iss_cmd = SMZ_WR;
      end
      OP_ZQ_LONG: begin
        // RULE20 explicit long calibration
        iss_cmd = SMZ_LONG_IMPEDANCE_CALIBRATION;
        iss_nxt = S_CAL;
        iss_tmr = zq_done_ff ? TMR_W'(OPERATING_CALIBRATION_CYC) :
          TMR_W'(INITIAL_CALIBRATION_CYC);
      end
      OP_ZQ_SHORT: begin
        iss_cmd = SMZ_SHORT_IMPEDANCE_CALIBRATION;
        iss_nxt = S_CAL;
        iss_tmr = TMR_W'(SHORT_CALIBRATION_CYC);
      end
      default: begin
        iss_cmd = SMZ_NOP;
      end
    endcase
  end

  assign tmr_load = pre || fire || rec;
  // RULE13 recovery before exit
  assign tmr_val = pre ? TMR_W'(PRECHARGE_PERIOD_CYC) :
    (rec ? TMR_W'(PATTERN_READ_RECOVERY_CYC) : iss_tmr);

  smz_timer u_tmr (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(tmr_load),
    .val_i(tmr_val),
    .zero_o(tmr_zero)
  );

  // ==========================================================
  // Sequencer
  // RULE19 quiet during calibration
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= S_IDLE;
      op_ff <= OP_MRS;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (go) begin
            op_ff <= reg_wdata_i[2:0];
            state_ff <= need_pre ? S_TRP : iss_nxt;
          end
        end
        S_TRP: begin
          if (tmr_zero) begin
            state_ff <= iss_nxt;
          end
        end
        S_RDW: begin
          if (rd_end) begin
            state_ff <= S_REC;
          end
        end
        // RULE21 calibrations never overlap
        S_WAIT, S_CAL, S_REC: begin
          if (tmr_zero) begin
            state_ff <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Link command, address and write data; one cycle per command.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_ff <= SMZ_NOP;
      a_ff <= 14'h0000;
      ba_ff <= 3'h0;
      wdq_ff <= 16'h0000;
      wdq_oe_ff <= 1'b0;
    end else begin
      cmd_ff <= fire ? iss_cmd : (pre ? SMZ_PREA : SMZ_NOP);
      wdq_oe_ff <= fire && (op_sel == OP_WRITE);
      if (fire) begin
        a_ff <= iss_addr;
        // RULE14 bank picks register
        ba_ff <= (op_sel == OP_MRS) ? bank_ff : 3'h0;
        wdq_ff <= wdata_ff;
      end
    end
  end

  // Track readout mode and first long calibration.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readout_ff <= 1'b0;
      zq_done_ff <= 1'b0;
    end else if (fire) begin
      if (op_sel == OP_MRS && bank_ff == MR3_SELECT) begin
        readout_ff <= addr_ff[MR3_ENABLE_BIT];
      end
      if (op_sel == OP_ZQ_LONG) begin
        zq_done_ff <= 1'b1;
      end
    end
  end

  // RULE22 clock enable and termination
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cke_ff <= 1'b0;
      odt_ff <= 1'b0;
    end else begin
      cke_ff <= 1'b1;
      odt_ff <= odt_en_ff && (state_ff == S_IDLE) && !go;
    end
  end

  // Capture the pattern bits into successive bits, from bit 4 when address bit two is sent high, else from bit 0.
  // Each read starts from an empty capture, so short bursts show as such.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_ff <= 8'h00;
      idx_ff <= 3'h0;
      seen_ff <= 1'b0;
    end else if (fire && op_sel == OP_READ) begin
      cap_ff <= 8'h00;
      idx_ff <= {iss_addr[ADDR_NIBBLE_BIT], 2'h0};
      seen_ff <= 1'b0;
    end else if (state_ff == S_RDW && link.dev_dq_oe) begin
      // RULE6 beat to bit
      cap_ff[idx_ff] <= link.dq[0];
      idx_ff <= idx_ff + 3'h1;
      seen_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Register port
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_ff <= 14'h0000;
      bank_ff <= 3'h0;
      wdata_ff <= 16'h0000;
      odt_en_ff <= 1'b0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        REG_ADDR: addr_ff <= reg_wdata_i[13:0];
        REG_BANK: bank_ff <= reg_wdata_i[2:0];
        REG_WDATA: wdata_ff <= reg_wdata_i;
        REG_STATUS: odt_en_ff <= reg_wdata_i[ST_ODT_BIT];
        default: begin
        end
      endcase
    end
  end

  // Refused orders set a sticky error; the set wins over the clear.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_ff <= 1'b0;
    end else if (cmd_wr && refuse) begin
      err_ff <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == REG_STATUS &&
        reg_wdata_i[ST_ERR_BIT]) begin
      err_ff <= 1'b0;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CMD: rdata_ff <= {13'h0000, op_ff};
        REG_ADDR: rdata_ff <= {2'h0, addr_ff};
        REG_BANK: rdata_ff <= {13'h0000, bank_ff};
        REG_WDATA: rdata_ff <= wdata_ff;
        REG_STATUS: rdata_ff <= {12'h000, odt_en_ff, err_ff, readout_ff,
          state_ff != S_IDLE};
        REG_CAPTURE: rdata_ff <= {8'h00, cap_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign link.cmd = cmd_ff;
  assign link.cke = cke_ff;
  assign link.on_die_termination = odt_ff;
  assign link.ba = ba_ff;
  assign link.addr = a_ff;
  assign link.ctl_dq = wdq_ff;
  assign link.ctl_dq_oe = wdq_oe_ff;
endmodule
`default_nettype wire

// file: smz_link_properties.sv
// Checker for the command and data link between the two ends.
`timescale 1ns/1ps
`default_nettype none
module smz_link_properties (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire smz_pkg::smz_cmd_e cmd,
  input wire logic cke,
  input wire logic on_die_termination,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic dev_dq_oe,
  input wire logic [15:0] dq,
  input wire logic all_lines_i
);
  import smz_pkg::*;
  logic rdo_ff;
  logic [9:0] quiet_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ========================================================
  // Helpers
  // Follows the readout enable last sent to register three.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdo_ff <= 1'b0;
    end else if (cmd == SMZ_MRS && ba == MR3_SELECT) begin
      rdo_ff <= addr[MR3_ENABLE_BIT];
    end
  end
  // Counts down the quiet time after a calibration command.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      quiet_ff <= 10'h000;
    end else if (cmd == SMZ_LONG_IMPEDANCE_CALIBRATION) begin
      quiet_ff <= 10'(OPERATING_CALIBRATION_CYC - 1);
    end else if (cmd == SMZ_SHORT_IMPEDANCE_CALIBRATION) begin
      quiet_ff <= 10'(SHORT_CALIBRATION_CYC - 1);
    end else if (quiet_ff != 10'h000) begin
      quiet_ff <= quiet_ff - 10'h001;
    end
  end
  // The read latency wait, then the pattern beats.
  sequence s_wait_rl;
    (!dev_dq_oe) [*5] ##1 dev_dq_oe;
  endsequence
  sequence s_pattern;
    !dq[0] ##1 dq[0] ##1 !dq[0] ##1 dq[0];
  endsequence

  // ========================================================
  // Properties
  a_cke_high: assert property ($past(arst_n_i) |-> cke)
    else $error("clock enable dropped");
  a_zq_quiet: assert property (quiet_ff != 0 |-> cmd == SMZ_NOP)
    else $error("command during calibration");
  a_zq_odt_off: assert property (quiet_ff != 0 |-> !on_die_termination)
    else $error("termination on during calibration");
  a_zq_after_pre: assert property (
    cmd inside {SMZ_LONG_IMPEDANCE_CALIBRATION, SMZ_SHORT_IMPEDANCE_CALIBRATION} |-> $past(cmd, 2) == SMZ_PREA)
    else $error("calibration without precharge");
  a_mrs_when_idle: assert property (
    cmd == SMZ_MRS |-> !dev_dq_oe && (rdo_ff || $past(cmd, 2) == SMZ_PREA))
    else $error("mode set while banks busy");
  a_mrs_gap: assert property (
    cmd == SMZ_MRS |=> (cmd == SMZ_NOP) [*4])
    else $error("command inside mode set gap");
  a_no_write_rdo: assert property (rdo_ff |-> cmd != SMZ_WR)
    else $error("write during readout");
  a_rdo_reads_only: assert property (
    rdo_ff |-> cmd inside {SMZ_NOP, SMZ_RD, SMZ_RDA, SMZ_MRS})
    else $error("illegal command during readout");
  a_col_bits_low: assert property (
    rdo_ff && cmd inside {SMZ_RD, SMZ_RDA} |-> addr[1:0] == 2'h0)
    else $error("column bits not zero");
  a_eight_nibble: assert property (
    cmd == SMZ_RD && addr[ADDR_CHOP_BIT] |-> !addr[ADDR_NIBBLE_BIT])
    else $error("eight-beat read with nibble bit set");
  a_read_latency: assert property (
    rdo_ff && cmd == SMZ_RD |-> s_wait_rl)
    else $error("pattern read latency wrong");
  a_pattern_bits: assert property (
    rdo_ff && $rose(dev_dq_oe) |-> s_pattern)
    else $error("pattern beats wrong");
  a_prime_lines: assert property (
    rdo_ff && dev_dq_oe |-> dq == (all_lines_i ? {16{dq[0]}} :
      {7'h00, dq[0], 7'h00, dq[0]}))
    else $error("pattern lines wrong");
endmodule
`default_nettype wire

// file: sdram_mpr_mrs_zq_cmds_bench.sv
// Bench joining controller and device over the command link.
`timescale 1ns/1ps
`default_nettype none
module sdram_mpr_mrs_zq_cmds_bench;
  import smz_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic all_lines_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic readout_on_o;
  logic cal_busy_o;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int cal_cyc = 0;
  int cal_mark = 0;
  logic [15:0] st;
  logic [15:0] cap;
  logic [7:0] masks [3] = '{8'hff, 8'h0f, 8'hf0};
  logic [13:0] adrs [3] = '{14'h1004, 14'h0000, 14'h0004};

  smz_link_if link ();
  smz_ctl u_smz_ctl (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  smz_dev u_smz_dev (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link),
    .all_lines_i(all_lines_i), .readout_on_o(readout_on_o),
    .cal_busy_o(cal_busy_o));
  smz_link_properties u_smz_link_properties (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .cmd(link.cmd), .cke(link.cke), .on_die_termination(link.on_die_termination),
    .ba(link.ba), .addr(link.addr), .dev_dq_oe(link.dev_dq_oe),
    .dq(link.dq), .all_lines_i(all_lines_i));

  // Clock generator, 50 ns period.
  always #25 clk_i = ~clk_i;

  // Counts cycles of calibration, and cuts a hang short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cal_busy_o === 1'b1) begin
      cal_cyc <= cal_cyc + 1;
    end
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ========================================================
  // Tasks
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string msg);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Issues an operation and polls until the controller is idle.
  task automatic op(input logic [2:0] code);
    int n;
    n = 0;
    wr(REG_CMD, {13'h0000, code});
    st = 16'h0001;
    while (st[ST_BUSY_BIT] !== 1'b0 && n < 2000) begin
      rd(REG_STATUS, st);
      n++;
    end
    if (n == 2000) begin
      chk(st, 16'h0000, "busy stuck");
    end
  endtask
  task automatic issue(input logic [2:0] b, input logic [13:0] a,
    input logic [2:0] code);
    wr(REG_BANK, {13'h0000, b});
    wr(REG_ADDR, {2'h0, a});
    op(code);
  endtask

  // ========================================================
  // Tests
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(REG_STATUS, st);
    chk(st, 16'h0000, "status after reset");
    rd(4'hf, st);
    chk(st, 16'h0000, "unmapped read");
    $display("test reset done");
    wr(REG_STATUS, 16'h0008);
    cal_mark = cal_cyc;
    op(OP_ZQ_LONG);
    chk(16'(cal_cyc - cal_mark), 16'(INITIAL_CALIBRATION_CYC),
      "long cal");
    cal_mark = cal_cyc;
    op(OP_ZQ_SHORT);
    chk(16'(cal_cyc - cal_mark), 16'(SHORT_CALIBRATION_CYC),
      "short cal");
    rd(REG_STATUS, st);
    chk(st, 16'h0008, "status after cal");
    $display("test calibration done");
    issue(3'h0, 14'h0000, OP_MRS);
    issue(MR3_SELECT, 14'h0004, OP_MRS);
    rd(REG_STATUS, st);
    chk(st[ST_READOUT_BIT], 1'b1, "readout status");
    chk(readout_on_o, 1'b1, "readout pin");
    issue(3'h7, 14'h2ff8, OP_READ);
    rd(REG_CAPTURE, cap);
    chk(cap[7:0], CAL_PATTERN, "eight-beat pattern");
    $display("test pattern read done");
    op(OP_WRITE);
    rd(REG_STATUS, st);
    chk(st[ST_ERR_BIT], 1'b1, "write not refused");
    wr(REG_STATUS, 16'h000c);
    op(OP_ZQ_SHORT);
    rd(REG_STATUS, st);
    chk(st[ST_ERR_BIT], 1'b1, "cal not refused");
    wr(REG_STATUS, 16'h000c);
    $display("test refusals done");
    issue(MR3_SELECT, 14'h0000, OP_MRS);
    issue(3'h0, 14'h0001, OP_MRS);
    issue(MR3_SELECT, 14'h0004, OP_MRS);
    all_lines_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      issue(3'h0, adrs[i], OP_READ);
      rd(REG_CAPTURE, cap);
      chk(cap[7:0], CAL_PATTERN & masks[i], "chop");
    end
    $display("test chop done");
    issue(MR3_SELECT, 14'h0000, OP_MRS);
    rd(REG_STATUS, st);
    chk(st[ST_READOUT_BIT], 1'b0, "readout left");
    chk(readout_on_o, 1'b0, "readout pin off");
    wr(REG_WDATA, 16'h5a5b);
    op(OP_WRITE);
    rd(REG_STATUS, st);
    chk(st[ST_ERR_BIT], 1'b0, "write refused");
    op(OP_READ);
    rd(REG_CAPTURE, cap);
    chk(cap, 16'h000f, "array read after exit");
    $display("test exit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
